// file: verilog/sfw_pkg.sv
/*
 Constants and carrier types for the software fault watchdog.
 Assumes a single 100 MHz clock domain.
*/
package sfw_pkg;
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned TICK_CYCLES   = 65536;
  localparam int unsigned TICK_W        = 16;
  localparam int unsigned WAKE_CYCLES   = 514;
  localparam int unsigned WAKE_W        = 10;
  localparam int unsigned PULSE_NS      = 500;
  localparam int unsigned PULSE_CYCLES  = (PULSE_NS * CLK_MHZ) / 1000;
  localparam int unsigned PULSE_W       = 8;
  localparam int unsigned ACT_BIT       = 7;
  localparam int unsigned TOP_BIT       = 6;
  localparam logic [7:0]  CTRL_RESET    = 8'h7f;
  localparam logic [6:0]  CNT_EXPIRE    = 7'h3f;

  typedef enum logic [1:0] {
    SFW_RUN   = 2'b00,
    SFW_HALT  = 2'b01,
    SFW_WAKE  = 2'b11
  } sfw_mode_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] data;
  } sfw_write_t;
endpackage

// file: verilog/sfw_divider.sv
/*
 Prescaler giving a one-cycle enable every TICK cycles while run is high.
 Assumes clear restarts the count on a counter reload.
*/
`timescale 1ns/1ns
module sfw_divider #(
  parameter int unsigned TICK = sfw_pkg::TICK_CYCLES,
  parameter int unsigned W    = sfw_pkg::TICK_W
) (
  input  wire logic clock,  // System clock
  input  wire logic rst,    // Async reset
  input  wire logic run,    // Count enable
  input  wire logic clear,  // Restart count
  output logic      tick    // One-cycle enable
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } sfw_div_state_t;

  sfw_div_state_t s_q;
  sfw_div_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (clear) begin
      s_d.cnt = '0;
    end else if (run) begin
      if (s_q.cnt == W'(TICK - 1)) begin
        s_d.cnt = '0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule

// file: verilog/sfw_watchdog.sv
/*
 Software fault watchdog: seven-bit downcounter, activation bit, reset
 pulse generation, option and low-power handling.
 Assumes the CPU write strobe, halt and wake inputs are synchronous.
*/
// Summary of operation
// - Count decrements once per 65,536 cycles; 64 timeout steps.
// - When active and count goes 40h to 3Fh, drive reset low.
// - Counting continues while inactive; only reset depends on activation.
// - At 8 MHz, FFh gives 524.288 ms and C0h gives 8.192 ms.
// - Software option: inactive after reset, writes cannot deactivate.
// - Write with activate set and top bit clear resets immediately.
// - Hardware option: always active; activation bit ignored.
// - Wait mode has no effect on counting or reset.
// - In halt, counting stops and no watchdog reset is made.
// - After wake by interrupt, counting resumes after 514 clocks.
// - Software option: leaving halt by reset makes watchdog inactive.
// - Activate at bit 7, count at bits 6..0; reset value 7Fh.
// - Activate bit set by software only, cleared only by reset.
`timescale 1ns/1ns
module sfw_watchdog #(
  parameter int unsigned TICK = sfw_pkg::TICK_CYCLES
) (
  input  wire logic         clock,        // 100 MHz clock
  input  wire logic         rst,          // Async reset, high
  input  wire logic         hw_option,    // Hardware watchdog option
  input  wire sfw_pkg::sfw_write_t ctrl_wr, // Control write
  input  wire logic         halt_enter,   // Halt instruction pulse
  input  wire logic         wake_irq,     // External interrupt wake pulse
  input  wire logic         wait_mode,    // Wait mode level, no effect
  output logic [7:0]        watchdog_control, // Control read value
  output logic              reset_n_out,  // Reset pin, low active
  output logic              halted        // Counter held by halt
);
  typedef struct packed {
    logic                      act;
    logic [6:0]                cnt;
    sfw_pkg::sfw_mode_t        mode;
    logic [sfw_pkg::WAKE_W-1:0]  wake_cnt;
    logic [sfw_pkg::PULSE_W-1:0] pulse_cnt;
    logic                      rst_n;
  } sfw_state_t;

  sfw_state_t s_q;
  sfw_state_t s_d;
  logic       tick;
  logic       run;
  logic       reload;
  logic       active;
  logic       fire;

  localparam logic [sfw_pkg::WAKE_W-1:0] WAKE_LAST =
    sfw_pkg::WAKE_W'(sfw_pkg::WAKE_CYCLES - 1);
  localparam logic [sfw_pkg::PULSE_W-1:0] PULSE_LEN =
    sfw_pkg::PULSE_W'(sfw_pkg::PULSE_CYCLES);

  // A write with top bit clear fires at once when hw_option or the written activate bit is set
  function automatic logic write_fires(
    input logic       hw,
    input logic [7:0] data
  );
    return (hw | data[sfw_pkg::ACT_BIT]) && !data[sfw_pkg::TOP_BIT];
  endfunction

  // True when the next decrement clears the top count bit
  function automatic logic rolls_over(
    input logic [6:0] cur
  );
    return cur[sfw_pkg::TOP_BIT] &&
           (7'(cur - 7'h01) == sfw_pkg::CNT_EXPIRE);
  endfunction

  // Wait mode is deliberately unused here
  assign run    = (s_q.mode == sfw_pkg::SFW_RUN);
  assign reload = ctrl_wr.wr;
  assign active = hw_option | s_q.act;

  sfw_divider #(
    .TICK (TICK),
    .W    (sfw_pkg::TICK_W)
  ) u_div (
    .clock (clock),
    .rst   (rst),
    .run   (run),
    .clear (reload),
    .tick  (tick)
  );

  always_comb begin
    s_d = s_q;
    fire = 1'b0;
    if (ctrl_wr.wr) begin
      // Activation only sets; clearing needs a reset
      s_d.act = s_q.act | ctrl_wr.data[sfw_pkg::ACT_BIT];
      s_d.cnt = ctrl_wr.data[6:0];
      if (write_fires(hw_option, ctrl_wr.data)) begin
        fire = 1'b1;
      end
    end else if (run && tick) begin
      s_d.cnt = s_q.cnt - 7'h01;
      if (rolls_over(s_q.cnt) && active) begin
        fire = 1'b1;
      end
    end
    case (s_q.mode)
      sfw_pkg::SFW_RUN: begin
        if (halt_enter) begin
          s_d.mode = sfw_pkg::SFW_HALT;
        end
      end
      sfw_pkg::SFW_HALT: begin
        if (wake_irq) begin
          s_d.mode = sfw_pkg::SFW_WAKE;
          s_d.wake_cnt = '0;
        end
      end
      sfw_pkg::SFW_WAKE: begin
        if (s_q.wake_cnt == WAKE_LAST) begin
          s_d.mode = sfw_pkg::SFW_RUN;
        end else begin
          s_d.wake_cnt = s_q.wake_cnt + 1'b1;
        end
      end
      default: begin
        s_d.mode = sfw_pkg::SFW_RUN;
      end
    endcase
    if (fire) begin
      s_d.pulse_cnt = PULSE_LEN;
      s_d.rst_n = 1'b0;
    end else if (s_q.pulse_cnt > 1) begin
      s_d.pulse_cnt = s_q.pulse_cnt - 1'b1;
    end else begin
      s_d.pulse_cnt = '0;
      s_d.rst_n = 1'b1;
    end
  end

  // Reset clears activation and halt state as well
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q.act       <= sfw_pkg::CTRL_RESET[7];
      s_q.cnt       <= sfw_pkg::CTRL_RESET[6:0];
      s_q.mode      <= sfw_pkg::SFW_RUN;
      s_q.wake_cnt  <= '0;
      s_q.pulse_cnt <= '0;
      s_q.rst_n     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      watchdog_control <= sfw_pkg::CTRL_RESET;
      halted           <= 1'b0;
    end else begin
      watchdog_control <= {s_d.act, s_d.cnt};
      halted           <= (s_d.mode != sfw_pkg::SFW_RUN);
    end
  end
  assign reset_n_out = s_q.rst_n;

  expire_fire_a: assert property (@(posedge clock) disable iff (rst)
    (run && tick && !ctrl_wr.wr && active && s_q.cnt == 7'h40)
      |=> !reset_n_out)
    else $error("Expiry did not pull reset low");

  inactive_quiet_a: assert property (@(posedge clock) disable iff (rst)
    (!ctrl_wr.wr && !hw_option && !s_q.act && reset_n_out)
      |=> reset_n_out)
    else $error("Inactive watchdog pulled reset");

  pulse_width_a: assert property (@(posedge clock) disable iff (rst)
    $fell(reset_n_out)
      |-> ##49 (!reset_n_out && s_q.pulse_cnt == 8'h01)
      ##1 reset_n_out)
    else $error("Reset pulse shape wrong");

  act_sticky_a: assert property (@(posedge clock) disable iff (rst)
    s_q.act |=> s_q.act)
    else $error("Activation bit was cleared");

  soft_reset_a: assert property (@(posedge clock) disable iff (rst)
    (ctrl_wr.wr && ctrl_wr.data[7] && !ctrl_wr.data[6])
      |=> !reset_n_out)
    else $error("Software reset not issued");

  halt_hold_a: assert property (@(posedge clock) disable iff (rst)
    (s_q.mode == sfw_pkg::SFW_HALT && !ctrl_wr.wr)
      |=> $stable(s_q.cnt))
    else $error("Count moved during halt");

  wake_delay_a: assert property (@(posedge clock) disable iff (rst)
    (s_q.mode == sfw_pkg::SFW_HALT && wake_irq)
      |=> (s_q.mode == sfw_pkg::SFW_WAKE) [*8])
    else $error("Wake delay too short");

  write_load_a: assert property (@(posedge clock) disable iff (rst)
    ctrl_wr.wr |=> s_q.cnt == $past(ctrl_wr.data[6:0]))
    else $error("Write did not load count");

  hw_active_a: assert property (@(posedge clock) disable iff (rst)
    (hw_option && run && tick && !ctrl_wr.wr && s_q.cnt == 7'h40)
      |=> !reset_n_out)
    else $error("Hardware option did not fire");

  wake_count_a: assert property (@(posedge clock) disable iff (rst)
    (s_q.mode == sfw_pkg::SFW_WAKE && s_q.wake_cnt != WAKE_LAST)
      |=> (s_q.mode == sfw_pkg::SFW_WAKE &&
           s_q.wake_cnt == $past(s_q.wake_cnt) + 1'b1))
    else $error("Wake counter did not advance");

  wake_end_a: assert property (@(posedge clock) disable iff (rst)
    (s_q.mode == sfw_pkg::SFW_WAKE && s_q.wake_cnt == WAKE_LAST)
      |=> s_q.mode == sfw_pkg::SFW_RUN)
    else $error("Wake delay did not end");

  wake_start_a: assert property (@(posedge clock) disable iff (rst)
    (s_q.mode == sfw_pkg::SFW_HALT && wake_irq)
      |=> s_q.wake_cnt == '0)
    else $error("Wake counter not cleared");

  wake_frozen_a: assert property (@(posedge clock) disable iff (rst)
    (s_q.mode == sfw_pkg::SFW_WAKE && !ctrl_wr.wr)
      |=> $stable(s_q.cnt))
    else $error("Count moved during wake delay");

  halt_entry_a: assert property (@(posedge clock) disable iff (rst)
    (s_q.mode == sfw_pkg::SFW_RUN && halt_enter)
      |=> s_q.mode == sfw_pkg::SFW_HALT)
    else $error("Halt not entered");

  halt_stay_a: assert property (@(posedge clock) disable iff (rst)
    (s_q.mode == sfw_pkg::SFW_HALT && !wake_irq)
      |=> s_q.mode == sfw_pkg::SFW_HALT)
    else $error("Halt left without wake");

  halt_quiet_a: assert property (@(posedge clock) disable iff (rst)
    (s_q.mode == sfw_pkg::SFW_HALT && !ctrl_wr.wr && reset_n_out)
      |=> reset_n_out)
    else $error("Reset pulled during halt");

  halted_flag_a: assert property (@(posedge clock) disable iff (rst)
    halted == (s_q.mode != sfw_pkg::SFW_RUN))
    else $error("Halted flag out of step");

  tick_step_a: assert property (@(posedge clock) disable iff (rst)
    (run && tick && !ctrl_wr.wr)
      |=> s_q.cnt == $past(s_q.cnt) - 7'h01)
    else $error("Tick did not decrement");

  no_tick_a: assert property (@(posedge clock) disable iff (rst)
    (!ctrl_wr.wr && !(run && tick))
      |=> $stable(s_q.cnt))
    else $error("Count moved without tick");

  tick_single_a: assert property (@(posedge clock) disable iff (rst)
    tick
      |=> !tick)
    else $error("Tick longer than one cycle");

  free_run_a: assert property (@(posedge clock) disable iff (rst)
    (!active && run && tick && !ctrl_wr.wr && rolls_over(s_q.cnt) &&
     reset_n_out)
      |=> (reset_n_out && s_q.cnt == sfw_pkg::CNT_EXPIRE))
    else $error("Inactive rollover misbehaved");

  pulse_level_a: assert property (@(posedge clock) disable iff (rst)
    reset_n_out == (s_q.pulse_cnt == '0))
    else $error("Pulse counter and pin disagree");

  pulse_start_a: assert property (@(posedge clock) disable iff (rst)
    $fell(reset_n_out)
      |-> s_q.pulse_cnt == PULSE_LEN)
    else $error("Pulse started with wrong length");

  early_quiet_a: assert property (@(posedge clock) disable iff (rst)
    (run && tick && !ctrl_wr.wr && !rolls_over(s_q.cnt) && reset_n_out)
      |=> reset_n_out)
    else $error("Reset pulled before rollover");

  top_set_a: assert property (@(posedge clock) disable iff (rst)
    (ctrl_wr.wr && ctrl_wr.data[sfw_pkg::TOP_BIT] && reset_n_out)
      |=> reset_n_out)
    else $error("Refresh write pulled reset");

  hw_soft_a: assert property (@(posedge clock) disable iff (rst)
    (hw_option && ctrl_wr.wr && !ctrl_wr.data[sfw_pkg::TOP_BIT])
      |=> !reset_n_out)
    else $error("Hardware option write did not fire");

  act_set_a: assert property (@(posedge clock) disable iff (rst)
    (ctrl_wr.wr && ctrl_wr.data[sfw_pkg::ACT_BIT])
      |=> s_q.act)
    else $error("Activation write ignored");

  act_hold_a: assert property (@(posedge clock) disable iff (rst)
    (!s_q.act && !(ctrl_wr.wr && ctrl_wr.data[sfw_pkg::ACT_BIT]))
      |=> !s_q.act)
    else $error("Activation set without write");

  read_back_a: assert property (@(posedge clock) disable iff (rst)
    watchdog_control == {s_q.act, s_q.cnt})
    else $error("Read value out of step");
endmodule

// file: test/software_fault_watchdog_bench.sv
/*
 Self-checking bench for the software fault watchdog.
 Assumes TICK shortened to 16 and a 50 cycle reset pulse.
*/
`timescale 1ns/1ns
module software_fault_watchdog_bench;
  localparam int T = 16;
  logic                clock = 0;
  logic                rst = 1;
  logic                hw_option = 0;
  logic                halt_enter = 0;
  logic                wake_irq = 0;
  logic                wait_mode = 0;
  sfw_pkg::sfw_write_t ctrl_wr = '0;
  logic [7:0]          watchdog_control;
  logic                reset_n_out;
  logic                halted;
  int                  n_mismatch = 0;
  int                  tests_run = 0;
  int                  n;
  logic [7:0]          v;

  sfw_watchdog #(.TICK(T)) DUT (
    .clock(clock), .rst(rst), .hw_option(hw_option), .ctrl_wr(ctrl_wr),
    .halt_enter(halt_enter), .wake_irq(wake_irq), .wait_mode(wait_mode),
    .watchdog_control(watchdog_control), .reset_n_out(reset_n_out),
    .halted(halted));

  always #5 clock = ~clock;
  // Wait mode wanders throughout; no result may depend on it
  always @(posedge clock) wait_mode <= 1'($urandom);

  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic wr(logic [7:0] d);
    @(posedge clock);
    ctrl_wr <= '{wr: 1'b1, data: d};
    @(posedge clock);
    ctrl_wr.wr <= 1'b0;
  endtask

  task automatic go(logic hw);
    @(posedge clock);
    rst <= 1'b1;
    hw_option <= hw;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    cyc(1);
  endtask

  // Bounded wait for the pin to drop; running out ends the run
  task automatic low_in(int b);
    #1;
    tests_run++;
    n = 0;
    while (reset_n_out !== 1'b0) begin
      n++;
      if (n > b) begin
        n_mismatch++;
        $display("unexpected reset pin expected 0 seen %b", reset_n_out);
        stop_test();
      end
      cyc(1);
    end
  endtask

  task automatic width();
    n = 0;
    while (reset_n_out === 1'b0 && n < 200) begin
      n++;
      cyc(1);
    end
    chk("pulse width", 8'(n), 8'h32);
  endtask

  initial begin
    void'($urandom(32'h62c45e82));
    go(1'b0);
    chk("reset value", watchdog_control, 8'h7f);
    for (int i = 0; i < 4; i++) begin
      v = {1'b0, 7'($urandom)};
      wr(v);
      cyc(T + 4);
      chk("count", watchdog_control, {1'b0, v[6:0] - 7'h01});
    end
    wr(8'h41);
    cyc(2 * T + 4);
    chk("free count", watchdog_control, 8'h3f);
    chk("quiet pin", {7'h00, reset_n_out}, 8'h01);
    wr(8'h00);
    cyc(T + 4);
    chk("wrap", watchdog_control, 8'h7f);
    wr(8'hc1);
    wr(8'h41);
    cyc(T + 4);
    chk("sticky", watchdog_control, 8'hc0);
    chk("early pin", {7'h00, reset_n_out}, 8'h01);
    low_in(T);
    width();
    go(1'b0);
    chk("deactivated", watchdog_control, 8'h7f);
    wr(8'h80);
    low_in(1);
    width();
    go(1'b1);
    wr(8'h41);
    low_in(2 * T + 4);
    width();
    go(1'b0);
    wr(8'hc1);
    halt_enter <= 1'b1;
    @(posedge clock);
    halt_enter <= 1'b0;
    cyc(100);
    chk("halt count", watchdog_control, 8'hc1);
    chk("halt pin", {halted, 6'h00, reset_n_out}, 8'h81);
    @(posedge clock);
    wake_irq <= 1'b1;
    @(posedge clock);
    wake_irq <= 1'b0;
    n = 0;
    while (halted === 1'b1 && n < 600) begin
      n++;
      cyc(1);
    end
    chk("wake delay", {7'h00, n >= 512 && n <= 518}, 8'h01);
    chk("held count", watchdog_control, 8'hc1);
    cyc(T + 4);
    chk("resumed", watchdog_control, 8'hc0);
    wr(8'hc1);
    halt_enter <= 1'b1;
    @(posedge clock);
    halt_enter <= 1'b0;
    go(1'b0);
    chk("halt reset", {watchdog_control[7], 6'h00, halted}, 8'h00);
    stop_test();
  end
endmodule
